// ### hdl/uart_fifo_shadow_ninebit_ctrl.sv
/*
  Extended control and status block of a serial port: FIFO levels,
  software restarts, shadow controls, DMA abort, baud fraction and the
  nine-bit multidrop character paths.
  Assumes the base register block feeds its direct control writes in,
  the FIFOs report their counts, and the shifters take nine-bit chars.
*/
module uart_fifo_shadow_ninebit_ctrl (
  input  wire  logic                   core_clk,
  input  wire  logic                   rst,
  input  wire  uart_ext_pkg::wb_req_t  wbReq,
  output logic [31:0]                  wbDatOut,
  output logic                         wbAck,
  input  wire  uart_ext_pkg::direct_wr_t directWr,
  output uart_ext_pkg::port_ctrl_t     portCtrl,
  output logic                         txFifoRestart,
  output logic                         rxFifoRestart,
  output logic                         portRestart,
  output logic                         dmaAbort,
  input  wire  logic [3:0]             txFifoCount,
  input  wire  logic [3:0]             rxFifoCount,
  output logic                         txFifoEmpty,
  output logic                         rxFifoNotEmpty,
  input  wire  logic [7:0]             rxAddrIn,
  input  wire  logic [7:0]             txAddrIn,
  input  wire  logic [15:0]            divisorInt,
  output logic                         baudTick,
  input  wire  logic [7:0]             txFifoData,
  input  wire  logic                   txFifoValid,
  output logic                         txFifoPop,
  output logic [8:0]                   txChar,
  output logic                         txCharValid,
  output logic                         txCharWide,
  input  wire  logic                   txCharReady,
  input  wire  logic [8:0]             rxChar,
  input  wire  logic                   rxCharValid,
  output logic [7:0]                   rxData,
  output logic                         rxPush
);
  import uart_ext_pkg::*;

  logic        ackQ;
  logic [31:0] datQ;
  port_ctrl_t  ctrlQ;
  logic        txRstQ;
  logic        rxRstQ;
  logic        portRstQ;
  logic        abortQ;
  logic [3:0]  txCountQ;
  logic [3:0]  rxCountQ;
  logic        txEmptyQ;
  logic        rxNotEmptyQ;
  logic [3:0]  fractionQ;
  logic [7:0]  rxAddrQ;
  logic [7:0]  txAddrQ;
  logic [3:0]  extQ;
  logic        txWideQ;
  logic [15:0] baudCntQ;
  logic [3:0]  fracAccQ;
  logic        baudTickQ;
  logic [8:0]  txCharQ;
  logic        txValidQ;
  logic        txPopQ;
  logic        matchedQ;
  logic [7:0]  rxDataQ;
  logic        rxPushQ;
  logic        busReq;
  logic        wrEn;
  logic [31:0] rdData;
  logic        nineBit;
  logic [4:0]  fracSum;

  assign busReq  = wbReq.cyc & wbReq.stb;
  assign wrEn    = busReq & wbReq.we & ackQ & wbReq.sel[0];
  assign nineBit = extQ[EXT_WORD_EXT_BIT];
  assign fracSum = {1'b0, fracAccQ} + {1'b0, fractionQ};

  // a write takes effect only at the edge where the master sees ack
  function automatic logic wrHit(input logic [7:0] ofs);
    wrHit = wrEn && (wbReq.adr == ofs);
  endfunction : wrHit

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  // ack one cycle after the request, dropped in the following cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ackQ <= 1'b0;
      datQ <= 32'h0000_0000;
    end else begin
      ackQ <= busReq & ~ackQ;
      if (busReq & ~ackQ) begin
        datQ <= rdData;
      end
    end
  end

  // read mux, unmapped offsets read as zero
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (wbReq.adr)
      TX_FIFO_LEVEL_OFS:   rdData[3:0] = txCountQ;
      RX_FIFO_LEVEL_OFS:   rdData[3:0] = rxCountQ;
      SOFT_RESTART_OFS:    rdData[2:0] = {txRstQ, rxRstQ, portRstQ};
      SHADOW_RTS_OFS:      rdData[0]   = ctrlQ.requestToSend;
      SHADOW_LINE6_OFS:    rdData[0]   = ctrlQ.lineCtrlBit6;
      SHADOW_FIFO_EN_OFS:  rdData[0]   = ctrlQ.fifoEnable;
      SHADOW_RX_TRIG_OFS:  rdData[1:0] = ctrlQ.rxTrigger;
      SHADOW_TXE_TRIG_OFS: rdData[1:0] = ctrlQ.txEmptyTrigger;
      DMA_ABORT_OFS:       rdData[0]   = abortQ;
      BAUD_FRACTION_OFS:   rdData[3:0] = fractionQ;
      RX_MATCH_ADDR_OFS:   rdData[7:0] = rxAddrQ;
      TX_ADDR_OFS:         rdData[7:0] = txAddrQ;
      EXT_LINE_CTRL_OFS:   rdData[3:0] = extQ;
      STATUS_OFS: begin
        rdData[STAT_TFE_BIT]  = txEmptyQ;
        rdData[STAT_RFNE_BIT] = rxNotEmptyQ;
      end
      default:             rdData = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // mirrored port controls: shadow writes and direct writes share one flop

  always_ff @(posedge core_clk) begin
    if (rst || portRstQ) begin
      ctrlQ <= CTRL_RESET;
    end else begin
      if (directWr.fifoCtrlWe) begin
        ctrlQ.fifoEnable     <= directWr.fifoCtrlData[FIFO_CTRL_EN_BIT];
        ctrlQ.rxTrigger      <= directWr.fifoCtrlData[FIFO_CTRL_RXT_LSB +: 2];
        ctrlQ.txEmptyTrigger <= directWr.fifoCtrlData[FIFO_CTRL_TXE_LSB +: 2];
      end
      if (directWr.modemCtrlWe) begin
        ctrlQ.requestToSend <= directWr.modemCtrlRts;
      end
      if (directWr.lineCtrlWe) begin
        ctrlQ.lineCtrlBit6 <= directWr.lineCtrlBit6;
      end
      if (wrHit(SHADOW_RTS_OFS)) begin
        ctrlQ.requestToSend <= wbReq.dat[0];
      end
      if (wrHit(SHADOW_LINE6_OFS)) begin
        ctrlQ.lineCtrlBit6 <= wbReq.dat[0];
      end
      if (wrHit(SHADOW_FIFO_EN_OFS)) begin
        ctrlQ.fifoEnable <= wbReq.dat[0];
      end
      if (wrHit(SHADOW_RX_TRIG_OFS)) begin
        ctrlQ.rxTrigger <= wbReq.dat[1:0];
      end
      if (wrHit(SHADOW_TXE_TRIG_OFS)) begin
        ctrlQ.txEmptyTrigger <= wbReq.dat[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // restarts and dma abort: self-clearing one-cycle pulses

  always_ff @(posedge core_clk) begin
    if (rst) begin
      txRstQ   <= 1'b0;
      rxRstQ   <= 1'b0;
      portRstQ <= 1'b0;
    end else begin
      txRstQ   <= (wrHit(SOFT_RESTART_OFS) && wbReq.dat[RESTART_TX_BIT])
                | (directWr.fifoCtrlWe && directWr.fifoCtrlData[FIFO_CTRL_TXRST_BIT]);
      rxRstQ   <= (wrHit(SOFT_RESTART_OFS) && wbReq.dat[RESTART_RX_BIT])
                | (directWr.fifoCtrlWe && directWr.fifoCtrlData[FIFO_CTRL_RXRST_BIT]);
      portRstQ <= wrHit(SOFT_RESTART_OFS) && wbReq.dat[RESTART_PORT_BIT];
    end
  end

  restart_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    wrHit(SOFT_RESTART_OFS) && wbReq.dat[RESTART_PORT_BIT]
      |=> portRstQ ##1 (!portRstQ && ctrlQ == CTRL_RESET))
    else $error("port restart not a single pulse clearing controls");

  // abort held exactly one cycle after the write, then cleared by hardware
  always_ff @(posedge core_clk) begin
    if (rst || portRstQ) begin
      abortQ <= 1'b0;
    end else begin
      abortQ <= wrHit(DMA_ABORT_OFS) && wbReq.dat[0];
    end
  end

  dma_abort_a: assert property (@(posedge core_clk) disable iff (rst)
    wrHit(DMA_ABORT_OFS) && wbReq.dat[0] && !portRstQ |=> abortQ ##1 !abortQ)
    else $error("dma abort did not pulse and self clear");

  ////////////////////////////////////////////////////////////////////////////
  // fifo levels and status

  always_ff @(posedge core_clk) begin
    if (rst || portRstQ) begin
      txCountQ    <= 4'h0;
      rxCountQ    <= 4'h0;
      txEmptyQ    <= 1'b1;
      rxNotEmptyQ <= 1'b0;
    end else begin
      txCountQ    <= txFifoCount;
      rxCountQ    <= rxFifoCount;
      txEmptyQ    <= (txFifoCount == 4'h0);
      rxNotEmptyQ <= (rxFifoCount != 4'h0);
    end
  end

  status_match_a: assert property (@(posedge core_clk) disable iff (rst)
    !portRstQ |=> (txEmptyQ == ($past(txFifoCount) == 4'h0))
      && (rxNotEmptyQ == ($past(rxFifoCount) != 4'h0)))
    else $error("fifo status disagrees with fifo level");

  ////////////////////////////////////////////////////////////////////////////
  // baud fraction, address registers, extended line control

  always_ff @(posedge core_clk) begin
    if (rst || portRstQ) begin
      fractionQ <= FRACTION_RESET;
      extQ      <= EXT_CTRL_RESET;
      txWideQ   <= 1'b0;
      rxAddrQ   <= ADDR_RESET;
      txAddrQ   <= ADDR_RESET;
    end else begin
      rxAddrQ <= rxAddrIn;
      txWideQ <= extQ[EXT_MODE_BIT] & extQ[EXT_WORD_EXT_BIT];
      txAddrQ <= txAddrIn;
      if (wrHit(BAUD_FRACTION_OFS)) begin
        fractionQ <= wbReq.dat[3:0];
      end
      if (wrHit(EXT_LINE_CTRL_OFS)) begin
        extQ <= wbReq.dat[3:0];
      end else if (txValidQ && txCharReady && txCharQ[8]) begin
        extQ[EXT_SEND_BIT] <= 1'b0;   // one address character per request
      end
    end
  end

  // divisor counter; fraction accumulator stretches a period by one cycle
  always_ff @(posedge core_clk) begin
    if (rst || portRstQ) begin
      baudCntQ  <= 16'h0000;
      fracAccQ  <= 4'h0;
      baudTickQ <= 1'b0;
    end else if (divisorInt == 16'h0000) begin
      baudCntQ  <= 16'h0000;
      baudTickQ <= 1'b0;
    end else if (baudCntQ == 16'h0000) begin
      fracAccQ  <= fracSum[3:0];
      baudCntQ  <= divisorInt - 16'h0001 + {15'h0000, fracSum[4]};
      baudTickQ <= 1'b1;
    end else begin
      baudCntQ  <= baudCntQ - 16'h0001;
      baudTickQ <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit character path

  always_ff @(posedge core_clk) begin
    if (rst || portRstQ || txRstQ) begin
      txCharQ  <= 9'h000;
      txValidQ <= 1'b0;
      txPopQ   <= 1'b0;
    end else begin
      txPopQ <= 1'b0;
      if (!txValidQ || txCharReady) begin
        txValidQ <= 1'b0;
        if (nineBit && extQ[EXT_SEND_BIT]
            && !(txValidQ && txCharQ[8])) begin
          txCharQ  <= {1'b1, txAddrQ};
          txValidQ <= 1'b1;
        end else if (txFifoValid && !txPopQ) begin
          txCharQ  <= {1'b0, txFifoData};
          txValidQ <= 1'b1;
          txPopQ   <= 1'b1;
        end
      end
    end
  end

  tx_address_a: assert property (@(posedge core_clk) disable iff (rst)
    (!txValidQ || txCharReady) && nineBit && extQ[EXT_SEND_BIT]
      && !(txValidQ && txCharQ[8]) && !portRstQ && !txRstQ
      |=> txValidQ && txCharQ == {1'b1, $past(txAddrQ)} && !txPopQ)
    else $error("address character not taken from transmit address");

  tx_data_a: assert property (@(posedge core_clk) disable iff (rst)
    txPopQ |-> txValidQ && !txCharQ[8] && txCharQ[7:0] == $past(txFifoData))
    else $error("data character not taken from fifo with ninth bit zero");

  ////////////////////////////////////////////////////////////////////////////
  // receive character path with address filtering

  always_ff @(posedge core_clk) begin
    if (rst || portRstQ || rxRstQ) begin
      matchedQ <= 1'b0;
      rxDataQ  <= 8'h00;
      rxPushQ  <= 1'b0;
    end else begin
      rxPushQ <= 1'b0;
      if (rxCharValid) begin
        if (nineBit && extQ[EXT_MATCH_BIT]) begin
          if (rxChar[8]) begin
            matchedQ <= (rxChar[7:0] == rxAddrQ);
          end else if (matchedQ) begin
            rxDataQ <= rxChar[7:0];
            rxPushQ <= 1'b1;
          end
        end else begin
          rxDataQ <= rxChar[7:0];
          rxPushQ <= 1'b1;
        end
      end
    end
  end

  rx_address_a: assert property (@(posedge core_clk) disable iff (rst)
    rxCharValid && rxChar[8] && nineBit && extQ[EXT_MATCH_BIT]
      && !portRstQ && !rxRstQ
      |=> !rxPushQ && matchedQ == ($past(rxChar[7:0]) == $past(rxAddrQ)))
    else $error("address character stored or compared wrongly");

  rx_filter_a: assert property (@(posedge core_clk) disable iff (rst)
    rxCharValid && !rxChar[8] && nineBit && extQ[EXT_MATCH_BIT] && !portRstQ
      && !rxRstQ |=> rxPushQ == $past(matchedQ))
    else $error("data character filtering wrong");

  rx_normal_a: assert property (@(posedge core_clk) disable iff (rst)
    rxCharValid && !(nineBit && extQ[EXT_MATCH_BIT]) && !portRstQ && !rxRstQ
      |=> rxPushQ && rxDataQ == $past(rxChar[7:0]))
    else $error("normal receive dropped a character");

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign wbDatOut       = datQ;
  assign wbAck          = ackQ;
  assign portCtrl       = ctrlQ;
  assign txFifoRestart  = txRstQ;
  assign rxFifoRestart  = rxRstQ;
  assign portRestart    = portRstQ;
  assign dmaAbort       = abortQ;
  assign txFifoEmpty    = txEmptyQ;
  assign rxFifoNotEmpty = rxNotEmptyQ;
  assign baudTick       = baudTickQ;
  assign txFifoPop      = txPopQ;
  assign txChar         = txCharQ;
  assign txCharValid    = txValidQ;
  assign txCharWide     = txWideQ;
  assign rxData         = rxDataQ;
  assign rxPush         = rxPushQ;

  ack_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    busReq && !ackQ |=> ackQ ##1 !ackQ)
    else $error("ack not a single pulse one cycle after request");

  tx_width_a: assert property (@(posedge core_clk) disable iff (rst)
    !portRstQ |=> txCharWide == ($past(extQ[EXT_MODE_BIT]) && $past(extQ[EXT_WORD_EXT_BIT])))
    else $error("nine bit transmit without width extension");

endmodule : uart_fifo_shadow_ninebit_ctrl

// ### hdl/uart_ext_pkg.sv
/*
  Package for the extended control and status block of a serial port.
  Holds register offsets, field positions, reset values and the packed
  carriers shared by the block and its surroundings.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
// Overview of operation
// - transmit FIFO entry count readable, four bits
// - receive FIFO entry count readable, four bits
// - restart bit two mirrors transmit FIFO restart
// - restart bit one mirrors receive FIFO restart
// - restart bit zero restarts whole port
// - shadow bit mirrors request-to-send control
// - shadow bit mirrors line control bit six
// - shadow bit mirrors FIFO enable control
// - shadow field mirrors receive trigger level
// - shadow field mirrors transmit empty trigger
// - abort bit aborts DMA, then self clears
// - four-bit baud fraction, applied in generator
// - ninth bit set: compare with receive address
// - after match accept data; otherwise drop
// - transmit path nine or eight bits wide
// - send-address: ninth bit one, transmit address
// - otherwise ninth bit zero, data from FIFO
// - matching disabled: normal receive, no compare
// - nine-bit transfers only with width extension
// - transmit empty, receive not empty status
package uart_ext_pkg;

  localparam logic [7:0] TX_FIFO_LEVEL_OFS      = 8'h80;
  localparam logic [7:0] RX_FIFO_LEVEL_OFS      = 8'h84;
  localparam logic [7:0] SOFT_RESTART_OFS       = 8'h88;
  localparam logic [7:0] SHADOW_RTS_OFS         = 8'h8c;
  localparam logic [7:0] SHADOW_LINE6_OFS       = 8'h90;
  localparam logic [7:0] SHADOW_FIFO_EN_OFS     = 8'h98;
  localparam logic [7:0] SHADOW_RX_TRIG_OFS     = 8'h9c;
  localparam logic [7:0] SHADOW_TXE_TRIG_OFS    = 8'ha0;
  localparam logic [7:0] DMA_ABORT_OFS          = 8'ha8;
  localparam logic [7:0] BAUD_FRACTION_OFS      = 8'hc0;
  localparam logic [7:0] RX_MATCH_ADDR_OFS      = 8'hc4;
  localparam logic [7:0] TX_ADDR_OFS            = 8'hc8;
  localparam logic [7:0] EXT_LINE_CTRL_OFS      = 8'hcc;
  localparam logic [7:0] STATUS_OFS             = 8'h7c;

  // soft restart fields
  localparam int RESTART_PORT_BIT = 0;
  localparam int RESTART_RX_BIT   = 1;
  localparam int RESTART_TX_BIT   = 2;
  // extended line control fields
  localparam int EXT_WORD_EXT_BIT = 0;
  localparam int EXT_MATCH_BIT    = 1;
  localparam int EXT_SEND_BIT     = 2;
  localparam int EXT_MODE_BIT     = 3;
  // status fields
  localparam int STAT_TFE_BIT     = 2;
  localparam int STAT_RFNE_BIT    = 3;
  // fifo control byte fields as written directly
  localparam int FIFO_CTRL_EN_BIT    = 0;
  localparam int FIFO_CTRL_RXRST_BIT = 1;
  localparam int FIFO_CTRL_TXRST_BIT = 2;
  localparam int FIFO_CTRL_TXE_LSB   = 4;
  localparam int FIFO_CTRL_RXT_LSB   = 6;

  localparam logic [3:0] EXT_CTRL_RESET = 4'h0;
  localparam logic [3:0] FRACTION_RESET = 4'h0;
  localparam logic [7:0] ADDR_RESET     = 8'h00;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic       fifoCtrlWe;
    logic [7:0] fifoCtrlData;
    logic       modemCtrlWe;
    logic       modemCtrlRts;
    logic       lineCtrlWe;
    logic       lineCtrlBit6;
  } direct_wr_t;

  typedef struct packed {
    logic       fifoEnable;
    logic [1:0] rxTrigger;
    logic [1:0] txEmptyTrigger;
    logic       requestToSend;
    logic       lineCtrlBit6;
  } port_ctrl_t;

  localparam port_ctrl_t CTRL_RESET = '0;

endpackage : uart_ext_pkg

// ### verification/serial_node_model.sv
/*
  Remote serial node model: takes characters from the transmit path with
  prompt or stalling ready, and offers received characters one by one.
  Assumes one clock, rising edge, and a synchronous active-high reset.
*/
module serial_node_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic [8:0] txChar,
  input  wire logic       txCharValid,
  output logic            txCharReady,
  output logic [8:0]      rxChar,
  output logic            rxCharValid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] stallCnt = 2'h0;
  logic [8:0] got[$];

  initial begin
    txCharReady = 1'b0;
    rxChar = 9'h000;
    rxCharValid = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // take a char at each valid and ready edge; slow stalls three of four
  always @(posedge core_clk) begin
    stallCnt <= stallCnt + 2'h1;
    txCharReady <= !rst && (!slow || stallCnt == 2'h3);
    if (txCharValid && txCharReady) begin
      got.push_back(txChar);
    end
  end

  // offer one char for one cycle, then scramble the idle line
  task automatic send(input logic [8:0] c);
    @(posedge core_clk);
    rxChar <= c;
    rxCharValid <= 1'b1;
    @(posedge core_clk);
    rxChar <= ~c;
    rxCharValid <= 1'b0;
  endtask : send
endmodule : serial_node_model

// ### verification/uart_fifo_shadow_ninebit_ctrl_bench.sv
/*
  Bench for the serial port extended control block: register tasks over
  classic Wishbone and directed tests with expected values.
  Assumes the design package and the remote node model compile first.
*/
module uart_fifo_shadow_ninebit_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_ext_pkg::*;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        slow = 1'b0;
  wb_req_t     wbReq = '0;
  direct_wr_t  directWr = '0;
  port_ctrl_t  portCtrl;
  logic [31:0] wbDatOut;
  logic        wbAck, txFifoRestart, rxFifoRestart, portRestart, dmaAbort, baudTick;
  logic        txFifoEmpty, rxFifoNotEmpty, txFifoPop, txCharValid, txCharWide;
  logic        txCharReady, rxCharValid, rxPush;
  logic        txFifoValid = 1'b0;
  logic [3:0]  txFifoCount = 4'h0;
  logic [3:0]  rxFifoCount = 4'h0;
  logic [7:0]  rxAddrIn = 8'h00;
  logic [7:0]  txAddrIn = 8'h00;
  logic [7:0]  txFifoData = 8'h00;
  logic [7:0]  rxData;
  logic [15:0] divisorInt = 16'h0000;
  logic [8:0]  txChar, rxChar;
  logic [7:0]  txq[$];
  logic [7:0]  pushed[$];
  int          errors = 0;
  int          check_count = 0;
  int          nTxRst = 0, nRxRst = 0, nPort = 0, nAbort = 0;
  logic [7:0]  shOfs [5] = '{SHADOW_RTS_OFS, SHADOW_LINE6_OFS, SHADOW_FIFO_EN_OFS,
                             SHADOW_RX_TRIG_OFS, SHADOW_TXE_TRIG_OFS};
  logic [31:0] shAll [5] = '{32'h1, 32'h1, 32'h1, 32'h3, 32'h3};
  logic [31:0] shDir [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h2};
  logic [7:0]  zeroOfs [14] = '{TX_FIFO_LEVEL_OFS, RX_FIFO_LEVEL_OFS, SOFT_RESTART_OFS,
                                SHADOW_RTS_OFS, SHADOW_LINE6_OFS, SHADOW_FIFO_EN_OFS,
                                SHADOW_RX_TRIG_OFS, SHADOW_TXE_TRIG_OFS, DMA_ABORT_OFS,
                                BAUD_FRACTION_OFS, RX_MATCH_ADDR_OFS, TX_ADDR_OFS,
                                EXT_LINE_CTRL_OFS, 8'hf0};
  logic [8:0]  rxSeq [9] = '{9'h111, 9'h022, 9'h15a, 9'h077, 9'h078, 9'h112, 9'h023,
                             9'h144, 9'h055};
  logic [7:0]  rxExp [4] = '{8'h77, 8'h78, 8'h44, 8'h55};

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  uart_fifo_shadow_ninebit_ctrl u_dut (
    .core_clk(core_clk), .rst(rst), .wbReq(wbReq), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .directWr(directWr), .portCtrl(portCtrl), .txFifoRestart(txFifoRestart),
    .rxFifoRestart(rxFifoRestart), .portRestart(portRestart), .dmaAbort(dmaAbort),
    .txFifoCount(txFifoCount), .rxFifoCount(rxFifoCount), .txFifoEmpty(txFifoEmpty),
    .rxFifoNotEmpty(rxFifoNotEmpty), .rxAddrIn(rxAddrIn), .txAddrIn(txAddrIn),
    .divisorInt(divisorInt), .baudTick(baudTick), .txFifoData(txFifoData),
    .txFifoValid(txFifoValid), .txFifoPop(txFifoPop), .txChar(txChar),
    .txCharValid(txCharValid), .txCharWide(txCharWide), .txCharReady(txCharReady),
    .rxChar(rxChar), .rxCharValid(rxCharValid), .rxData(rxData), .rxPush(rxPush));

  serial_node_model u_node (
    .core_clk(core_clk), .rst(rst), .slow(slow), .txChar(txChar),
    .txCharValid(txCharValid), .txCharReady(txCharReady), .rxChar(rxChar),
    .rxCharValid(rxCharValid));

  ////////////////////////////////////////////////////////////
  // pulse counters, receive capture and a small transmit FIFO
  always @(posedge core_clk) begin
    nTxRst += txFifoRestart;
    nRxRst += rxFifoRestart;
    nPort += portRestart;
    nAbort += dmaAbort;
    if (rxPush === 1'b1) begin
      pushed.push_back(rxData);
    end
    if (txFifoPop === 1'b1 && txq.size() != 0) begin
      void'(txq.pop_front());
    end
    txFifoValid <= txq.size() != 0;
    txFifoData <= (txq.size() != 0) ? txq[0] : ~txFifoData;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_up(input string what);
    errors++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    wrap_up();
  endtask : give_up

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // one classic cycle; ack and read data taken at the same edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int i;
    @(posedge core_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (wbAck !== 1'b1 && i < 20);
    rd = wbDatOut;
    wbReq <= '0;
    if (wbAck !== 1'b1) begin
      give_up("bus ack");
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(n, r, e);
  endtask : rdchk

  // cycles spanned by sixteen baud periods
  task automatic span(output int cyc);
    int n;
    cyc = 0;
    n = 0;
    while (n < 17 && cyc < 400) begin
      @(posedge core_clk);
      if (n > 0) cyc++;
      if (baudTick === 1'b1) n++;
    end
    if (n < 17) give_up("baud ticks");
  endtask : span

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int i;
    int c;
    tick(12);
    rst <= 1'b0;
    foreach (zeroOfs[k]) rdchk("reset value", zeroOfs[k], 32'h0);
    rdchk("status reset", STATUS_OFS, 32'h4);
    chk("ctrl reset", 32'(portCtrl), 32'(CTRL_RESET));
    $display("test reset done");
    txFifoCount <= 4'h5;
    rxFifoCount <= 4'hf;
    wr(TX_FIFO_LEVEL_OFS, 32'h0);
    rdchk("tx level", TX_FIFO_LEVEL_OFS, 32'h5);
    rdchk("rx level", RX_FIFO_LEVEL_OFS, 32'hf);
    rdchk("status", STATUS_OFS, 32'h8);
    chk("tx empty", 32'(txFifoEmpty), 32'h0);
    chk("rx not empty", 32'(rxFifoNotEmpty), 32'h1);
    $display("test levels done");
    for (i = 0; i < 5; i++) wr(shOfs[i], 32'hffffffff);
    tick(2);
    chk("ctrl ones", 32'(portCtrl), 32'h7f);
    for (i = 0; i < 5; i++) rdchk("shadow ones", shOfs[i], shAll[i]);
    @(posedge core_clk);
    directWr <= '{fifoCtrlWe: 1'b1, fifoCtrlData: 8'h60, modemCtrlWe: 1'b1,
                  modemCtrlRts: 1'b0, lineCtrlWe: 1'b1, lineCtrlBit6: 1'b0};
    @(posedge core_clk);
    directWr <= '0;
    tick(2);
    chk("ctrl direct", 32'(portCtrl), 32'h18);
    for (i = 0; i < 5; i++) rdchk("shadow direct", shOfs[i], shDir[i]);
    wr(SHADOW_RTS_OFS, 32'h1);
    tick(2);
    chk("ctrl rts", 32'(portCtrl), 32'h1a);
    $display("test shadows done");
    wr(SOFT_RESTART_OFS, 32'h4);
    tick(3);
    chk("tx restarts", 32'(nTxRst), 32'h1);
    wr(SOFT_RESTART_OFS, 32'h2);
    tick(3);
    chk("rx restarts", 32'(nRxRst), 32'h1);
    chk("tx restarts", 32'(nTxRst), 32'h1);
    rdchk("restart", SOFT_RESTART_OFS, 32'h0);
    @(posedge core_clk);
    directWr <= '{fifoCtrlWe: 1'b1, fifoCtrlData: 8'h06, default: '0};
    @(posedge core_clk);
    directWr <= '0;
    tick(2);
    chk("direct tx restarts", 32'(nTxRst), 32'h2);
    chk("direct rx restarts", 32'(nRxRst), 32'h2);
    chk("ctrl direct fifo", 32'(portCtrl), 32'h2);
    wr(SOFT_RESTART_OFS, 32'h1);
    tick(3);
    chk("port restarts", 32'(nPort), 32'h1);
    chk("ctrl restarted", 32'(portCtrl), 32'h0);
    wr(DMA_ABORT_OFS, 32'h1);
    tick(3);
    chk("aborts", 32'(nAbort), 32'h1);
    rdchk("abort clear", DMA_ABORT_OFS, 32'h0);
    $display("test restart done");
    divisorInt <= 16'h0004;
    for (i = 0; i < 2; i++) begin
      wr(BAUD_FRACTION_OFS, 32'(i * 8));
      rdchk("fraction", BAUD_FRACTION_OFS, 32'(i * 8));
      span(c);
      chk("baud span", 32'(c), 32'(64 + i * 8));
    end
    divisorInt <= 16'h0000;
    $display("test baud done");
    rxAddrIn <= 8'h5a;
    txAddrIn <= 8'ha5;
    wr(RX_MATCH_ADDR_OFS, 32'h0);
    rdchk("rx addr", RX_MATCH_ADDR_OFS, 32'h5a);
    rdchk("tx addr", TX_ADDR_OFS, 32'ha5);
    for (i = 0; i < 3; i++) begin
      wr(EXT_LINE_CTRL_OFS, (i == 0) ? 32'h8 : 32'(i * 8 - 7));
      tick(2);
      chk("tx wide", 32'(txCharWide), 32'(i == 2));
    end
    slow <= 1'b1;
    wr(EXT_LINE_CTRL_OFS, 32'hd);
    txq.push_back(8'h33);
    txq.push_back(8'hcc);
    c = 0;
    while (u_node.got.size() < 3 && c < 300) begin
      @(posedge core_clk);
      c++;
    end
    if (c >= 300) give_up("tx chars");
    chk("addr char", 32'(u_node.got[0]), 32'h1a5);
    chk("data char", 32'(u_node.got[1]), 32'h033);
    chk("data char", 32'(u_node.got[2]), 32'h0cc);
    rdchk("send clear", EXT_LINE_CTRL_OFS, 32'h9);
    $display("test transmit done");
    slow <= 1'b0;
    wr(EXT_LINE_CTRL_OFS, 32'h3);
    for (i = 0; i < 9; i++) begin
      if (i == 7) wr(EXT_LINE_CTRL_OFS, 32'h0);
      u_node.send(rxSeq[i]);
    end
    tick(3);
    chk("pushes", 32'(pushed.size()), 32'h4);
    for (i = 0; i < 4; i++) chk("pushed", 32'(pushed[i]), 32'(rxExp[i]));
    $display("test receive done");
    wrap_up();
  end

  // cut a hang short
  initial begin
    repeat (50000) @(posedge core_clk);
    give_up("run");
  end
endmodule : uart_fifo_shadow_ninebit_ctrl_bench
